// ==== acs_config.sv ====
// channel configuration register bank with serial port, strap mode and slot counters
`timescale 1ns/1ns
module acs_config (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic port_select_strap,
  input wire logic [5:0] addr_pin,
  input wire logic ser_clk,
  input wire logic ser_data_in,
  input wire logic chip_sel_n,
  input wire logic x_bit_clock,
  input wire logic x_frame_sync,
  input wire logic y_bit_clock,
  input wire logic y_frame_sync,
  input wire logic [1:0] algo_rst_done,
  output acs_pkg::acs_chan_s x_cfg,
  output acs_pkg::acs_chan_s y_cfg,
  output acs_pkg::acs_stat_s x_stat,
  output acs_pkg::acs_stat_s y_stat
);
  import acs_pkg::*;

  // ==========================================================
  // decoding helpers
  // ==========================================================
  function automatic acs_rate_e rate_of(input logic [7:0] c);
    logic [2:0] s;
    s = {c[CTL_ALGO_SEL2], c[CTL_ALGO_SEL1], c[CTL_ALGO_SEL0]};
    case (s)
      3'h0: rate_of = ACS_RATE_32K;
      3'h7: rate_of = ACS_RATE_24K;
      3'h5: rate_of = ACS_RATE_16K;
      default: rate_of = ACS_RATE_BAD;
    endcase
  endfunction

  function automatic logic [6:0] slot_total(input logic [7:0] c, input logic wide);
    slot_total = c[CTL_LAW] ? (wide ? SLOTS_MU_WIDE : SLOTS_MU_NARROW)
                            : (wide ? SLOTS_A_WIDE : SLOTS_A_NARROW);
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] sdi_sync;
    logic [1:0] csn_sync;
    logic [1:0] strap_sync;
    logic [5:0] a_sync1;
    logic [5:0] a_sync2;
    acs_rx_e rx;
    logic [7:0] shift;
    logic [2:0] bitn;
    logic side_x;
    acs_chan_s chan_x;
    acs_chan_s chan_y;
    logic [1:0] rst_busy;
    logic [7:0] rst_cnt_x;
    logic [7:0] rst_cnt_y;
    logic [9:0] strap_timer;
    logic strap_low_seen;
    logic strap_24k;
    acs_side_s sx;
    acs_side_s sy;
  } acs_state_s;

  localparam acs_state_s STATE_RESET = '{
    sclk_sync: 3'h0, sdi_sync: 2'h0, csn_sync: 2'h3, strap_sync: 2'h3,
    a_sync1: 6'h00, a_sync2: 6'h00, rx: ACS_RX_CMD, shift: 8'h00, bitn: 3'h0,
    side_x: 1'b0,
    chan_x: '{ctl: CTL_RESET, in_slot: SLOT_RESET, out_slot: SLOT_RESET},
    chan_y: '{ctl: CTL_RESET, in_slot: SLOT_RESET, out_slot: SLOT_RESET},
    rst_busy: 2'h0, rst_cnt_x: 8'h00, rst_cnt_y: 8'h00,
    strap_timer: 10'h000, strap_low_seen: 1'b0, strap_24k: 1'b0,
    sx: '0, sy: '0};

  acs_state_s st_r;
  acs_state_s st_nxt;

  // slot counter step for one side
  function automatic acs_side_s side_step(input acs_side_s s, input logic bclk,
                                          input logic fs, input acs_chan_s c);
    acs_side_s n;
    logic rise;
    logic [3:0] w_in;
    logic [3:0] w_out;
    logic [2:0] b;
    logic adv_in;
    logic adv_out;
    n = s;
    n.clk_sync = {s.clk_sync[1:0], bclk};
    n.fs_sync = {s.fs_sync[0], fs};
    rise = s.clk_sync[1] & ~s.clk_sync[2];
    w_in = c.ctl[CTL_ENCODE] ? WIDE_SLOT_BITS : NARROW_SLOT_BITS;
    w_out = c.ctl[CTL_ENCODE] ? NARROW_SLOT_BITS : WIDE_SLOT_BITS;
    if (c.ctl[CTL_BYPASS])
      w_out = w_in;
    // bit_cnt is the bit index in an eight-bit group; nibble slots turn at 0 and 4
    b = s.bit_cnt[2:0] + 3'h1;
    adv_in = (b == 3'h0) || (b == 3'h4 && w_in == NARROW_SLOT_BITS);
    adv_out = (b == 3'h0) || (b == 3'h4 && w_out == NARROW_SLOT_BITS);
    n.in_hit = 1'b0;
    n.out_hit = 1'b0;
    if (s.fs_sync[1])
      n.armed = 1'b1;
    if (rise) begin
      if (s.armed) begin
        n.armed = s.fs_sync[1];
        n.counting = 1'b1;
        n.bit_cnt = 4'h0;
        n.in_slot = 7'h00;
        n.out_slot = 7'h00;
        n.in_hit = (c.in_slot == 6'h00);
        n.out_hit = (c.out_slot == 6'h00);
      end else if (s.counting) begin
        n.bit_cnt = {1'b0, b};
        if (adv_in)
          n.in_slot = s.in_slot + 7'h01;
        if (adv_out)
          n.out_slot = s.out_slot + 7'h01;
        // both layouts span the same bits, so the input side ends the frame
        if (n.in_slot >= slot_total(c.ctl, w_in == WIDE_SLOT_BITS))
          n.counting = 1'b0;
        n.in_hit = adv_in & n.counting & (n.in_slot == {1'b0, c.in_slot});
        n.out_hit = adv_out & n.counting & (n.out_slot == {1'b0, c.out_slot});
      end
    end
    side_step = n;
  endfunction

  // ==========================================================
  // next state
  // ==========================================================
  logic sclk_rise;
  logic strap_hw;
  logic [7:0] byte_in;
  logic [7:0] hw_ctl_x;
  logic [7:0] hw_ctl_y;
  logic [7:0] hw_rate_bits;
  logic [1:0] ctl_wr;

  always_comb begin
    st_nxt = st_r;
    ctl_wr = 2'b00;
    st_nxt.sclk_sync = {st_r.sclk_sync[1:0], ser_clk};
    st_nxt.sdi_sync = {st_r.sdi_sync[0], ser_data_in};
    st_nxt.csn_sync = {st_r.csn_sync[0], chip_sel_n};
    st_nxt.strap_sync = {st_r.strap_sync[0], port_select_strap};
    st_nxt.a_sync1 = addr_pin;
    st_nxt.a_sync2 = st_r.a_sync1;
    sclk_rise = st_r.sclk_sync[1] & ~st_r.sclk_sync[2];
    strap_hw = ~st_r.strap_sync[1];
    byte_in = {st_r.sdi_sync[1], st_r.shift[7:1]};
    // serial receiver
    if (strap_hw || st_r.csn_sync[1]) begin
      st_nxt.rx = ACS_RX_CMD;
      st_nxt.bitn = 3'h0;
    end else if (sclk_rise) begin
      st_nxt.shift = byte_in;
      st_nxt.bitn = st_r.bitn + 3'h1;
      if (st_r.bitn == 3'h7) begin
        case (st_r.rx)
          ACS_RX_CMD: begin
            st_nxt.side_x = byte_in[CMD_SIDE_BIT];
            st_nxt.rx = (byte_in[CMD_ADDR_MSB:0] == st_r.a_sync2) ? ACS_RX_CTL
                                                               : ACS_RX_SKIP;
          end
          ACS_RX_CTL: begin
            ctl_wr = st_r.side_x ? 2'b01 : 2'b10;
            if (st_r.side_x)
              st_nxt.chan_x.ctl = byte_in;
            else
              st_nxt.chan_y.ctl = byte_in;
            st_nxt.rx = ACS_RX_ISLOT;
          end
          ACS_RX_ISLOT: begin
            if (st_r.side_x)
              st_nxt.chan_x.in_slot = byte_in[5:0];
            else
              st_nxt.chan_y.in_slot = byte_in[5:0];
            st_nxt.rx = ACS_RX_OSLOT;
          end
          ACS_RX_OSLOT: begin
            if (st_r.side_x)
              st_nxt.chan_x.out_slot = byte_in[5:0];
            else
              st_nxt.chan_y.out_slot = byte_in[5:0];
            st_nxt.rx = ACS_RX_SKIP;
          end
          default: st_nxt.rx = ACS_RX_SKIP;
        endcase
      end
    end
    // algorithm reset self-clear
    for (int i = 0; i < 2; i++) begin
      if (i == 0 ? st_nxt.chan_x.ctl[CTL_ALGO_RST] : st_nxt.chan_y.ctl[CTL_ALGO_RST])
        st_nxt.rst_busy[i] = 1'b1;
    end
    if (st_r.rst_busy[0]) begin
      st_nxt.rst_cnt_x = st_r.rst_cnt_x + 8'h01;
      if (ctl_wr[0]) begin
        st_nxt.rst_cnt_x = 8'h00; // a fresh write beats the self-clear
      end else if (algo_rst_done[0] || st_r.rst_cnt_x == 8'(ALGO_RST_CYCLES - 1)) begin
        st_nxt.chan_x.ctl[CTL_ALGO_RST] = 1'b0;
        st_nxt.rst_busy[0] = 1'b0;
        st_nxt.rst_cnt_x = 8'h00;
      end
    end
    if (st_r.rst_busy[1]) begin
      st_nxt.rst_cnt_y = st_r.rst_cnt_y + 8'h01;
      if (ctl_wr[1]) begin
        st_nxt.rst_cnt_y = 8'h00; // a fresh write beats the self-clear
      end else if (algo_rst_done[1] || st_r.rst_cnt_y == 8'(ALGO_RST_CYCLES - 1)) begin
        st_nxt.chan_y.ctl[CTL_ALGO_RST] = 1'b0;
        st_nxt.rst_busy[1] = 1'b0;
        st_nxt.rst_cnt_y = 8'h00;
      end
    end
    // strap mode: pins drive control bits, slots at zero
    if (st_r.strap_timer != 10'(STRAP_DELAY_CYC))
      st_nxt.strap_timer = st_r.strap_timer + 10'h001;
    // pins reach a_sync2 two edges after release; raising them early means 16k
    if (st_r.strap_timer == 10'h002)
      st_nxt.strap_low_seen = ~st_r.a_sync2[1] & ~st_r.a_sync2[4];
    else if (st_r.a_sync2[1] & st_r.a_sync2[4] & (st_r.strap_timer != 10'(STRAP_DELAY_CYC)))
      st_nxt.strap_low_seen = 1'b0;
    if (st_r.a_sync2[1] & st_r.a_sync2[4] & ~st_r.strap_24k)
      st_nxt.strap_24k = st_r.strap_low_seen &&
                         st_r.strap_timer == 10'(STRAP_DELAY_CYC);
    if (~st_r.a_sync2[1] & ~st_r.a_sync2[4])
      st_nxt.strap_24k = 1'b0;
    hw_rate_bits = 8'h00;
    if (st_r.a_sync2[1] & st_r.a_sync2[4]) begin
      hw_rate_bits[CTL_ALGO_SEL0] = 1'b1;
      hw_rate_bits[CTL_ALGO_SEL2] = 1'b1;
      hw_rate_bits[CTL_ALGO_SEL1] = st_r.strap_24k;
    end
    hw_ctl_x = hw_rate_bits;
    hw_ctl_x[CTL_ENCODE] = st_r.a_sync2[0];
    hw_ctl_x[CTL_LAW] = st_r.a_sync2[2];
    hw_ctl_x[CTL_IDLE_PD] = st_r.csn_sync[1];
    hw_ctl_y = hw_rate_bits;
    hw_ctl_y[CTL_ENCODE] = st_r.a_sync2[3];
    hw_ctl_y[CTL_LAW] = st_r.a_sync2[5];
    hw_ctl_y[CTL_IDLE_PD] = st_r.sdi_sync[1];
    if (strap_hw) begin
      st_nxt.chan_x = '{ctl: hw_ctl_x, in_slot: SLOT_RESET, out_slot: SLOT_RESET};
      st_nxt.chan_y = '{ctl: hw_ctl_y, in_slot: SLOT_RESET, out_slot: SLOT_RESET};
      st_nxt.rst_busy = 2'h0;
      st_nxt.rst_cnt_x = 8'h00;
      st_nxt.rst_cnt_y = 8'h00;
    end
    st_nxt.sx = side_step(st_r.sx, x_bit_clock, x_frame_sync, st_r.chan_x);
    st_nxt.sy = side_step(st_r.sy, y_bit_clock, y_frame_sync, st_r.chan_y);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      st_r <= STATE_RESET;
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  function automatic acs_stat_s stat_of(input acs_chan_s c, input acs_side_s s,
                                        input logic updating);
    acs_stat_s o;
    o.enabled = ~c.ctl[CTL_IDLE_PD];
    o.bypass = c.ctl[CTL_BYPASS] & ~c.ctl[CTL_IDLE_PD];
    o.compress = c.ctl[CTL_ENCODE];
    o.mu_law = c.ctl[CTL_LAW];
    o.rate = rate_of(c.ctl);
    o.algo_rst = c.ctl[CTL_ALGO_RST];
    o.out_tristate = c.ctl[CTL_IDLE_PD] | updating;
    o.in_strobe = s.in_hit & ~c.ctl[CTL_IDLE_PD];
    o.out_strobe = s.out_hit & ~c.ctl[CTL_IDLE_PD];
    o.slot_bits = c.ctl[CTL_ENCODE] ? WIDE_SLOT_BITS : NARROW_SLOT_BITS;
    stat_of = o;
  endfunction

  logic updating;
  assign updating = (st_r.rx != ACS_RX_CMD) && (st_r.rx != ACS_RX_SKIP);
  assign x_cfg = st_r.chan_x;
  assign y_cfg = st_r.chan_y;
  assign x_stat = stat_of(st_r.chan_x, st_r.sx, updating & st_r.side_x);
  assign y_stat = stat_of(st_r.chan_y, st_r.sy, updating & ~st_r.side_x);
endmodule

// ==== acs_config_assertions.sv ====
// checker: port-level properties of the channel config block
`timescale 1ns/1ns
module acs_config_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic port_select_strap,
  input wire logic [5:0] addr_pin,
  input wire logic ser_data_in,
  input wire logic chip_sel_n,
  input acs_pkg::acs_chan_s x_cfg,
  input acs_pkg::acs_chan_s y_cfg,
  input acs_pkg::acs_stat_s x_stat,
  input acs_pkg::acs_stat_s y_stat
);
  import acs_pkg::*;
  logic [7:0] xc;
  logic [7:0] yc;
  assign xc = x_cfg.ctl;
  assign yc = y_cfg.ctl;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // =====
  // decode of the control byte
  a_bypass_decode: assert property (
    x_stat.bypass == (xc[CTL_BYPASS] && !xc[CTL_IDLE_PD])) else $error("bypass flag wrong");
  a_bypass_width: assert property (
    y_stat.bypass |-> y_stat.slot_bits == (yc[CTL_ENCODE] ? WIDE_SLOT_BITS : NARROW_SLOT_BITS))
    else $error("bypass slot width wrong");
  a_law_code: assert property (
    !yc[CTL_BYPASS] && !yc[CTL_IDLE_PD] |->
    y_stat.mu_law == yc[CTL_LAW] && y_stat.compress == yc[CTL_ENCODE])
    else $error("law or direction wrong");
  a_idle_off: assert property (
    x_stat.enabled == !xc[CTL_IDLE_PD] && (!xc[CTL_IDLE_PD] || x_stat.out_tristate))
    else $error("idle handling wrong");
  a_strobe_idle: assert property (
    x_stat.in_strobe || x_stat.out_strobe |-> !xc[CTL_IDLE_PD]) else $error("strobe while idle");
  a_rate_decode: assert property (
    (port_select_strap)[*4] ##0 {xc[1], xc[6], xc[7]} inside {3'h0, 3'h7, 3'h5} |->
    x_stat.rate == (xc[1] ? (xc[6] ? ACS_RATE_24K : ACS_RATE_16K) : ACS_RATE_32K))
    else $error("rate decode wrong");
  a_algo_clear: assert property (
    $rose(yc[CTL_ALGO_RST]) |-> ##[1:24] !yc[CTL_ALGO_RST]) else $error("algo reset stuck");
  // =====
  // strap mode
  a_strap_slots: assert property (
    (!port_select_strap)[*5] |->
    {x_cfg.in_slot, x_cfg.out_slot, y_cfg.in_slot, y_cfg.out_slot} == 24'h000000)
    else $error("strap slots not zero");
  a_strap_pins: assert property (
    (!port_select_strap && $stable({addr_pin, ser_data_in, chip_sel_n}))[*6] |->
    xc[CTL_ENCODE] == addr_pin[0] && yc[CTL_ENCODE] == addr_pin[3] &&
    xc[CTL_LAW] == addr_pin[2] && yc[CTL_LAW] == addr_pin[5] &&
    xc[CTL_IDLE_PD] == chip_sel_n && yc[CTL_IDLE_PD] == ser_data_in)
    else $error("strap pins not mapped");
endmodule

bind acs_config acs_config_chk chk_u (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .port_select_strap(port_select_strap),
  .addr_pin(addr_pin),
  .ser_data_in(ser_data_in),
  .chip_sel_n(chip_sel_n),
  .x_cfg(x_cfg),
  .y_cfg(y_cfg),
  .x_stat(x_stat),
  .y_stat(y_stat)
);

// ==== acs_config_tb.sv ====
// testbench: serial writes, slot timing and strap mode of the config block
`timescale 1ns/1ns
module acs_config_tb;
  import acs_pkg::*;
  typedef struct packed {
    logic side;
    logic [7:0] ctl;
    logic [5:0] isl;
    logic [5:0] osl;
    acs_chan_s exp;
  } acs_row_s;
  localparam logic [5:0] DEV_ADDR = 6'h2D;
  logic clk_sys, reset_n, port_select_strap;
  logic [5:0] addr_pin;
  logic ser_clk, ser_data_in, chip_sel_n;
  logic x_bit_clock, x_frame_sync, y_bit_clock, y_frame_sync;
  logic [3:0] stb;
  logic [1:0] algo_done;
  acs_chan_s x_cfg, y_cfg;
  acs_stat_s x_stat, y_stat;
  acs_row_s rows [6];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int rises = 0;
  int at [4];
  int rst_len [2] = '{0, 0};
  acs_config dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .port_select_strap(port_select_strap), .addr_pin(addr_pin), .ser_clk(ser_clk),
    .ser_data_in(ser_data_in), .chip_sel_n(chip_sel_n), .x_bit_clock(x_bit_clock),
    .x_frame_sync(x_frame_sync), .y_bit_clock(y_bit_clock), .y_frame_sync(y_frame_sync),
    .algo_rst_done(algo_done), .x_cfg(x_cfg), .y_cfg(y_cfg), .x_stat(x_stat), .y_stat(y_stat));
  acs_host host_u (.ser_clk(ser_clk), .ser_data_in(ser_data_in), .chip_sel_n(chip_sel_n));
  assign stb = {x_stat.in_strobe, x_stat.out_strobe, y_stat.in_strobe, y_stat.out_strobe};
  // =====
  // helpers
  task automatic chk(input string what, input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rst();
    @(posedge clk_sys);
    #1 reset_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  // one frame sync, then 24 bit clock rises on both sides
  task automatic frame();
    at = '{default: 0};
    rises = 0;
    x_frame_sync = 1'b1;
    y_frame_sync = 1'b1;
    #40;
    x_frame_sync = 1'b0;
    y_frame_sync = 1'b0;
    repeat (24) begin
      #40;
      x_bit_clock = 1'b1;
      y_bit_clock = 1'b1;
      rises++;
      #40;
      x_bit_clock = 1'b0;
      y_bit_clock = 1'b0;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  always @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      if (stb[k] === 1'b1 && at[k] == 0) begin
        at[k] <= rises;
      end
    end
    // cycles that each algo_reset bit stands
    if (x_cfg.ctl[CTL_ALGO_RST] === 1'b1) begin
      rst_len[0] <= rst_len[0] + 1;
    end
    if (y_cfg.ctl[CTL_ALGO_RST] === 1'b1) begin
      rst_len[1] <= rst_len[1] + 1;
    end
  end
  // =====
  // main sequence
  initial begin
    reset_n = 1'b0;
    port_select_strap = 1'b1;
    addr_pin = DEV_ADDR;
    {x_bit_clock, x_frame_sync, y_bit_clock, y_frame_sync} = 4'h0;
    algo_done = 2'b00;
    rows = '{
      '{1'b0, 8'h00, 6'h05, 6'h3F, {8'h00, 6'h05, 6'h3F}},
      '{1'b1, 8'hC7, 6'h3F, 6'h00, {8'hC7, 6'h3F, 6'h00}},
      '{1'b1, 8'h83, 6'h10, 6'h21, {8'h83, 6'h10, 6'h21}},
      '{1'b0, 8'h09, 6'h01, 6'h02, {8'h09, 6'h01, 6'h02}},
      '{1'b0, 8'h08, 6'h02, 6'h01, {8'h08, 6'h02, 6'h01}},
      '{1'b1, 8'h2C, 6'h00, 6'h00, {8'h2C, 6'h00, 6'h00}}};
    rst();
    foreach (rows[i]) begin
      host_u.send(4, rows[i].side, DEV_ADDR, rows[i].ctl, rows[i].isl, rows[i].osl);
      chk("row cfg", rows[i].side ? x_cfg : y_cfg, rows[i].exp);
    end
    $display("test rows finished");
    host_u.send(4, 1'b1, DEV_ADDR ^ 6'h01, 8'h01, 6'h07, 6'h07);
    chk("mismatch", x_cfg, {8'h2C, 6'h00, 6'h00});
    host_u.send(4, 1'b1, DEV_ADDR, 8'h05, 6'h01, 6'h03);
    host_u.send(2, 1'b1, DEV_ADDR, 8'hC7, 6'h3F, 6'h3F);
    chk("two byte", x_cfg, {8'hC7, 6'h01, 6'h03});
    algo_done = 2'b01;
    host_u.send(2, 1'b1, DEV_ADDR, 8'hD7, 6'h3F, 6'h3F);
    algo_done = 2'b00;
    chk("algo done", x_cfg, {8'hC7, 6'h01, 6'h03});
    chk("done length", 20'(rst_len[0]), 20'h1);
    host_u.send(4, 1'b0, DEV_ADDR, 8'h00, 6'h03, 6'h02);
    host_u.send(2, 1'b0, DEV_ADDR, 8'h10, 6'h00, 6'h00);
    repeat (30) @(posedge clk_sys);
    #1;
    chk("algo clear", y_cfg, {8'h00, 6'h03, 6'h02});
    chk("algo length", 20'(rst_len[1]), 20'(ALGO_RST_CYCLES));
    $display("test writes finished");
    frame();
    repeat (4) @(posedge clk_sys);
    chk("x in slot", 20'(at[3]), 20'h9);
    chk("x out slot", 20'(at[2]), 20'hD);
    chk("y in slot", 20'(at[1]), 20'hD);
    chk("y out slot", 20'(at[0]), 20'h11);
    $display("test slots finished");
    rst();
    chk("reset x", x_cfg, {CTL_RESET, SLOT_RESET, SLOT_RESET});
    chk("reset y", y_cfg, {CTL_RESET, SLOT_RESET, SLOT_RESET});
    port_select_strap = 1'b0;
    addr_pin = 6'h29;
    host_u.pins(1'b1, 1'b0);
    rst();
    chk("strap x", x_cfg, {8'h01, 6'h00, 6'h00});
    chk("strap y", y_cfg, {8'h25, 6'h00, 6'h00});
    chk("low pins", 20'(x_stat.rate), 20'(ACS_RATE_32K));
    repeat (400) @(posedge clk_sys);
    #1 addr_pin = 6'h3B;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("late pins", 20'(x_stat.rate), 20'(ACS_RATE_24K));
    rst();
    chk("high pins", 20'(y_stat.rate), 20'(ACS_RATE_16K));
    repeat (400) @(posedge clk_sys);
    #1;
    chk("high pins held", 20'(y_stat.rate), 20'(ACS_RATE_16K));
    $display("test strap finished");
    conclude();
  end
endmodule

// ==== acs_host.sv ====
// host model: drives the three-wire configuration port
`timescale 1ns/1ns
module acs_host (
  output logic ser_clk,
  output logic ser_data_in,
  output logic chip_sel_n
);
  import acs_pkg::*;
  initial begin
    ser_clk = 1'b0;
    ser_data_in = 1'b0;
    chip_sel_n = 1'b1;
  end
  // =====
  // one write: command, control, then both slot bytes when n is 4
  task automatic send(input int n, input logic side, input logic [5:0] addr,
      input logic [7:0] ctl, input logic [5:0] isl, input logic [5:0] osl);
    logic [31:0] w;
    w = {2'b00, osl, 2'b00, isl, ctl, 1'b0, side, addr};
    chip_sel_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      ser_data_in = w[i];
      #40 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
    end
    #40 chip_sel_n = 1'b1;
    ser_data_in = ~ser_data_in;
    #200;
  endtask
  task automatic pins(input logic sd, input logic cs);
    ser_data_in = sd;
    chip_sel_n = cs;
  endtask
endmodule

// ==== acs_pkg.sv ====
// package: constants, field layout and carriers for the channel config and slot assigner
package acs_pkg;
  // chan_ctrl bit positions
  localparam int CTL_ALGO_SEL0 = 7;
  localparam int CTL_ALGO_SEL1 = 6;
  localparam int CTL_IDLE_PD = 5;
  localparam int CTL_ALGO_RST = 4;
  localparam int CTL_BYPASS = 3;
  localparam int CTL_LAW = 2;
  localparam int CTL_ALGO_SEL2 = 1;
  localparam int CTL_ENCODE = 0;
  // command_byte field positions
  localparam int CMD_SIDE_BIT = 6;
  localparam int CMD_ADDR_MSB = 5;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h20;
  localparam logic [5:0] SLOT_RESET = 6'h00;
  // slot geometry
  localparam logic [3:0] WIDE_SLOT_BITS = 4'h8;
  localparam logic [3:0] NARROW_SLOT_BITS = 4'h4;
  localparam logic [6:0] SLOTS_MU_WIDE = 7'h20;
  localparam logic [6:0] SLOTS_MU_NARROW = 7'h40;
  localparam logic [6:0] SLOTS_A_WIDE = 7'h20;
  localparam logic [6:0] SLOTS_A_NARROW = 7'h40;
  // algorithm reset duration and strap 24k window
  localparam int ALGO_RST_CYCLES = 16;
  localparam int STRAP_DELAY_NS = 3000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ACS_RATE_32K, ACS_RATE_24K, ACS_RATE_16K, ACS_RATE_BAD} acs_rate_e;
  typedef enum {ACS_RX_CMD, ACS_RX_CTL, ACS_RX_ISLOT, ACS_RX_OSLOT, ACS_RX_SKIP} acs_rx_e;

  // per-channel configuration seen by the datapath
  typedef struct packed {
    logic [7:0] ctl;
    logic [5:0] in_slot;
    logic [5:0] out_slot;
  } acs_chan_s;

  // per-channel status toward the datapath
  typedef struct packed {
    logic enabled;
    logic bypass;
    logic compress;
    logic mu_law;
    acs_rate_e rate;
    logic algo_rst;
    logic out_tristate;
    logic in_strobe;
    logic out_strobe;
    logic [3:0] slot_bits;
  } acs_stat_s;

  // per-side slot counter state
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] fs_sync;
    logic armed;
    logic counting;
    logic [3:0] bit_cnt;
    logic [6:0] in_slot;
    logic [6:0] out_slot;
    logic in_hit;
    logic out_hit;
  } acs_side_s;
endpackage
